// ---- verilog/motor_cfg_consts.vh ----
// Purpose: constants for the motor drive configuration register bank
// Assumes: AXI4-Lite slave, 32-bit data, 16-bit registers in low bits
// Notes: printed offsets are register indexes, byte address is index*4
// Behaviour
// - second register at 0x91, resets zero
// - bits 15:14 select PWM dither spread
// - tach select: both, closed, closed+first open
// - speed pulse at electrical speed over n+1
// - bit 7 selects full or half cycle
// - resistance code is mantissa shifted by shift
// - bits 3:0 hold resistance mantissa
// - back-EMF constant: bits 11:8 shifted by 14:12
// - mode 0 keeps fixed advance time
// - mode 1 scales advance by bemf over supply
// - advance time: bits 3:0 shifted by 6:4
// - first register at 0x90, resets zero
`ifndef MOTOR_CFG_CONSTS_VH
`define MOTOR_CFG_CONSTS_VH
`define CFG1_INDEX      8'h90
`define CFG2_INDEX      8'h91
`define CFG_RESET       16'h0000
`define CFG2_WMASK      16'h7FFF
`define ADDR_W          10
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define F_DITHER_HI     15
`define F_DITHER_LO     14
`define F_TSEL_HI       13
`define F_TSEL_LO       12
`define F_POLE_HI       11
`define F_POLE_LO       8
`define F_CYCADJ        7
`define F_SHIFT_HI      6
`define F_SHIFT_LO      4
`define F_MANT_HI       3
`define F_MANT_LO       0
`define F_KSHIFT_HI     14
`define F_KSHIFT_LO     12
`define F_KMANT_HI      11
`define F_KMANT_LO      8
`define F_ADVMODE       7
`endif

// ---- verilog/cfg_reg16.v ----
// Purpose: one 16-bit configuration register with write mask
// Assumes: write strobe from the bus slave, same clock
// Notes: masked bits stay at their reset value
`timescale 1ns/10ps
`include "motor_cfg_consts.vh"
module cfg_reg16 #(
  parameter [15:0] WMASK = 16'hFFFF
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  input  wire [1:0]  wr_strb,
  output reg  [15:0] value_q
);
  wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & WMASK;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      value_q <= `CFG_RESET;
    end else if (wr_en) begin
      // only a software write moves the fields
      value_q <= (value_q & ~lane_mask) | (wr_data & lane_mask);
    end
  end
endmodule // cfg_reg16

// ---- verilog/shift_decode.v ----
// Purpose: expand a shift-plus-mantissa code to its full value
// Assumes: 4-bit mantissa, 3-bit shift count
// Notes: result is 11 bits, largest code 15<<7
`timescale 1ns/10ps
module shift_decode (
  input  wire [3:0]  mantissa,
  input  wire [2:0]  shift,
  output wire [10:0] value
);
  assign value = {7'h00, mantissa} << shift;
endmodule // shift_decode

// ---- verilog/motor_drive_config_regs.v ----
// Purpose: two configuration registers of a sensorless motor driver
// Assumes: AXI4-Lite master keeps one write and one read outstanding
// Notes: select fields feed the motor control engine unprocessed; shift-coded fields are expanded first
`timescale 1ns/10ps
`include "motor_cfg_consts.vh"
module motor_drive_config_regs (
  input  wire                 CLK,
  input  wire                 RESET,
  input  wire [`ADDR_W-1:0]   AWADDR,
  input  wire                 AWVALID,
  output wire                 AWREADY,
  input  wire [31:0]          WDATA,
  input  wire [3:0]           WSTRB,
  input  wire                 WVALID,
  output wire                 WREADY,
  output reg  [1:0]           BRESP,
  output reg                  BVALID,
  input  wire                 BREADY,
  input  wire [`ADDR_W-1:0]   ARADDR,
  input  wire                 ARVALID,
  output wire                 ARREADY,
  output reg  [31:0]          RDATA,
  output reg  [1:0]           RRESP,
  output reg                  RVALID,
  input  wire                 RREADY,
  output wire [1:0]           DITHER_SPREAD_SEL,
  output wire [1:0]           TACH_LOOP_PHASE_SEL,
  output wire [3:0]           TACH_POLE_DIVIDER,
  output wire                 CYCLE_ADJUST_SEL,
  output wire [10:0]          RESISTANCE_CODE,
  output wire [10:0]          BACKEMF_CONST,
  output wire                 ADVANCE_MODE_SEL,
  output wire [10:0]          ADVANCE_TIME
);
  reg  [`ADDR_W-1:0] awaddr_q;
  reg                aw_held_q;
  reg  [31:0]        wdata_q;
  reg  [3:0]         wstrb_q;
  reg                w_held_q;
  wire [15:0]        cfg1;
  wire [15:0]        cfg2;
  wire [`ADDR_W-3:0] widx = awaddr_q[`ADDR_W-1:2];
  wire [`ADDR_W-3:0] ridx = ARADDR[`ADDR_W-1:2];
  wire               do_write = aw_held_q & w_held_q & ~BVALID;
  wire               hit1 = (widx == {`CFG1_INDEX});
  wire               hit2 = (widx == {`CFG2_INDEX});

  // capture address and data independently, in either order
  assign AWREADY = ~aw_held_q & ~BVALID;
  assign WREADY  = ~w_held_q & ~BVALID;
  assign ARREADY = ~RVALID;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= {`ADDR_W{1'b0}};
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      BVALID    <= 1'b0;
      BRESP     <= `RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_q <= 1'b1;
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= (hit1 | hit2) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  cfg_reg16 #(
    .WMASK   (16'hFFFF)
  ) u_cfg1 (
    .clk     (CLK),
    .reset   (RESET),
    .wr_en   (do_write & hit1),
    .wr_data (wdata_q[15:0]),
    .wr_strb (wstrb_q[1:0]),
    .value_q (cfg1)
  );

  // reserved top bit never stored, so it reads zero
  cfg_reg16 #(
    .WMASK   (`CFG2_WMASK)
  ) u_cfg2 (
    .clk     (CLK),
    .reset   (RESET),
    .wr_en   (do_write & hit2),
    .wr_data (wdata_q[15:0]),
    .wr_strb (wstrb_q[1:0]),
    .value_q (cfg2)
  );

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h00000000;
      RRESP  <= `RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      if (ridx == {`CFG1_INDEX}) begin
        RDATA <= {16'h0000, cfg1};
        RRESP <= `RESP_OKAY;
      end else if (ridx == {`CFG2_INDEX}) begin
        RDATA <= {16'h0000, cfg2};
        RRESP <= `RESP_OKAY;
      end else begin
        RDATA <= 32'h00000000;
        RRESP <= `RESP_SLVERR;
      end
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // codes pass straight to the engine; 11 of tach select is reserved
  assign DITHER_SPREAD_SEL   = cfg1[`F_DITHER_HI:`F_DITHER_LO];
  assign TACH_LOOP_PHASE_SEL = cfg1[`F_TSEL_HI:`F_TSEL_LO];
  assign TACH_POLE_DIVIDER   = cfg1[`F_POLE_HI:`F_POLE_LO];
  assign CYCLE_ADJUST_SEL    = cfg1[`F_CYCADJ];
  assign ADVANCE_MODE_SEL    = cfg2[`F_ADVMODE];

  shift_decode u_res (
    .mantissa (cfg1[`F_MANT_HI:`F_MANT_LO]),
    .shift    (cfg1[`F_SHIFT_HI:`F_SHIFT_LO]),
    .value    (RESISTANCE_CODE)
  );

  shift_decode u_kt (
    .mantissa (cfg2[`F_KMANT_HI:`F_KMANT_LO]),
    .shift    (cfg2[`F_KSHIFT_HI:`F_KSHIFT_LO]),
    .value    (BACKEMF_CONST)
  );

  shift_decode u_adv (
    .mantissa (cfg2[`F_MANT_HI:`F_MANT_LO]),
    .shift    (cfg2[`F_SHIFT_HI:`F_SHIFT_LO]),
    .value    (ADVANCE_TIME)
  );
endmodule // motor_drive_config_regs

// ---- testbench/motor_cfg_props_properties.sv ----
// Purpose: bus and field checks for the motor configuration bank
// Assumes: bound to the top module, single clock domain
// Notes: slave answers a read one cycle after it is taken, a write two cycles after
`timescale 1ns/10ps
module motor_cfg_props (
  input wire        CLK, RESET, AWREADY, BVALID, BREADY,
  input wire        ARVALID, ARREADY, RVALID, RREADY,
  input wire [31:0] RDATA,
  input wire [10:0] BACKEMF_CONST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_bhold; BVALID && !BREADY |=> BVALID; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_bdone; BVALID && BREADY |=> !BVALID; endproperty
  a_bdone: assert property (p_bdone) else $error("bvalid stuck");
  property p_awblk; BVALID |-> !AWREADY; endproperty
  a_awblk: assert property (p_awblk) else $error("aw open");
  property p_rlat; ARVALID && ARREADY |=> RVALID; endproperty
  a_rlat: assert property (p_rlat) else $error("no read answer");
  property p_rhold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  property p_rdone; RVALID && RREADY |=> !RVALID && ARREADY; endproperty
  a_rdone: assert property (p_rdone) else $error("rvalid stuck");
  property p_upper; RVALID |-> RDATA[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper data set");
  property p_keep; !$rose(BVALID) |-> $stable(BACKEMF_CONST); endproperty
  a_keep: assert property (p_keep) else $error("field moved");
endmodule // motor_cfg_props
bind motor_drive_config_regs motor_cfg_props motor_cfg_props_i (.*);

// ---- testbench/motor_drive_config_regs_tb.sv ----
// Purpose: self-checking bench for the motor configuration bank
// Assumes: one bus transfer at a time
// Notes: handshakes sampled at the rising edge, before the slave updates
`timescale 1ns/10ps
`include "motor_cfg_consts.vh"
module motor_drive_config_regs_tb;
  logic        CLK = 0, RESET = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic        ARVALID = 0, RREADY = 0;
  logic [9:0]  AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, rdat;
  logic [3:0]  WSTRB = 4'hF;
  logic [1:0]  rsp;
  wire  [31:0] RDATA;
  wire  [1:0]  BRESP, RRESP, DITHER_SPREAD_SEL, TACH_LOOP_PHASE_SEL;
  wire  [3:0]  TACH_POLE_DIVIDER;
  wire  [10:0] RESISTANCE_CODE, BACKEMF_CONST, ADVANCE_TIME;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID;
  wire         CYCLE_ADJUST_SEL, ADVANCE_MODE_SEL;
  int          err_count = 0, cmp_count = 0, cyc = 0;
  localparam [9:0] adr1 = {`CFG1_INDEX, 2'b00}, adr2 = {`CFG2_INDEX, 2'b00};
  motor_drive_config_regs motor_drive_config_regs_i (.*);
  task chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task axi(input logic w, input logic [9:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge CLK);
    {AWADDR, ARADDR, WDATA} <= {a, a, d};
    {AWVALID, WVALID, BREADY} <= {3{w}};
    {ARVALID, RREADY} <= {2{!w}};
    do begin
      // sampled here before the slave's own updates of this edge land
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (BREADY && BVALID) begin
        done = 1'b1;
        rsp = BRESP;
      end
      if (RREADY && RVALID) begin
        done = 1'b1;
        rsp = RRESP;
        rdat = RDATA;
      end
    end while (!done);
    {BREADY, RREADY} <= 2'b00;
  endtask
  task t_rst2;
    axi(1'b1, adr1, 32'h0000001D);
    chk(RESISTANCE_CODE, 32'h1A);
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    chk(RESISTANCE_CODE, 32'h0);
    axi(1'b0, adr1, 32'h0);
    chk(rdat, 32'h0);
    $display("mid-run reset test done");
  endtask
  task t_reset;
    axi(1'b0, adr1, 32'h0);
    chk(rdat, 32'h0);
    axi(1'b0, adr2, 32'h0);
    chk(rdat, 32'h0);
    axi(1'b1, 10'h248, 32'h0000FFFF);
    chk(rsp, 2'h2);
    chk(RESISTANCE_CODE, 32'h0);
    $display("reset test done");
  endtask
  task t_fields;
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 16'h5555 * i[15:0];
      axi(1'b1, adr1, {16'hA5A5, v});
      chk(DITHER_SPREAD_SEL, i[1:0]);
      chk(TACH_LOOP_PHASE_SEL, i[1:0]);
      chk(TACH_POLE_DIVIDER, v[11:8]);
      chk(CYCLE_ADJUST_SEL, v[7]);
      chk(RESISTANCE_CODE, {7'h0, v[3:0]} << v[6:4]);
      axi(1'b1, adr2, {16'h5A5A, v});
      chk(BACKEMF_CONST, {7'h0, v[11:8]} << v[14:12]);
      chk(ADVANCE_MODE_SEL, v[7]);
      chk(ADVANCE_TIME, {7'h0, v[3:0]} << v[6:4]);
      axi(1'b0, adr2, 32'h0);
      chk(rdat, {17'h0, v[14:0]});
      axi(1'b0, adr1, 32'h0);
      chk(rdat, {16'h0, v});
    end
    $display("field test done");
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    t_reset;
    t_fields;
    t_rst2;
    end_sim;
  end
endmodule // motor_drive_config_regs_tb
